// >>> design/lsts_pin_sync.sv
`timescale 1ns/1ps
module lsts_pin_sync
  import lsts_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire logic     clk,
  input wire logic     rst,
  // raw pin
  input wire logic     raw_in,
  // cleaned result
  lsts_edge_if.src     edge_o
);

  lsts_sync_state_t q;
  lsts_sync_state_t d;

  ////////////////////////////////////////////////////////////////////////////
  // three stages; level moves only once stages two and three agree
  always_comb begin
    d       = q;
    d.s1    = raw_in;
    d.s2    = q.s1;
    d.s3    = q.s2;
    d.rise  = 1'b0;
    d.fall  = 1'b0;
    if (q.s2 == q.s3) begin
      d.level = q.s2;
      d.rise  = q.s2 & ~q.level;
      d.fall  = ~q.s2 & q.level;
    end
  end

  // register the whole state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{s1: RESET_LEVEL, s2: RESET_LEVEL, s3: RESET_LEVEL,
             level: RESET_LEVEL, rise: 1'b0, fall: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign edge_o.level = q.level;
  assign edge_o.rise  = q.rise;
  assign edge_o.fall  = q.fall;

  ////////////////////////////////////////////////////////////////////////////
  AST_PIN_FILTER_RISE: assert property (@(posedge clk) disable iff (rst)
    q.rise |-> q.level && !$past(q.level) && $past(q.s2) && $past(q.s3))
    else $error("rise pulse without agreed high stages");

  AST_PIN_FILTER_HOLD: assert property (@(posedge clk) disable iff (rst)
    $past(q.s2) != $past(q.s3) |-> $stable(q.level))
    else $error("level moved while stages disagreed");

endmodule : lsts_pin_sync

// >>> design/lsts_top.sv
`timescale 1ns/1ps
// How it works
// [RL1] In 8b/10b modes with source select 0 the active-low single-ended pin carries the request.
// [RL2] In 64b/66b modes the sync request never starts link bring-up.
// [RL3] In 64b/66b modes a falling sync level gives an oscillator synchronisation pulse.
// [RL4] A low sync level in 8b/10b modes starts code group synchronisation.
// [RL5] Lane alignment starts only on the rising sync edge that ends code group sync.
// [RL6] With source select 1 the request comes from the differential marker pair.
// [RL7] With marker enable set the differential pair tags the sample it coincides with.
// [RL8] The pair may be sync source and marker at once, feeding the sync level into the tag.
// [RL9] The pair used as sync source is active low, like the single-ended pin.
// [RL10] The pair is ignored for sync and marking unless its receiver enable is set.
// [RL11] With the pair selected, the single-ended pin is disregarded entirely.
module lsts_top
  import lsts_pkg::*;
(
  // clock and reset
  input wire logic  clk,
  input wire logic  rst,
  // sync and marker pins, already buffered to logic levels
  input wire logic  single_ended_sync_in,
  input wire logic  marker_diff_in,
  // configuration bits
  input wire logic  link_mode_64b66b,
  input wire logic  sync_source_select,
  input wire logic  marker_enable,
  input wire logic  marker_receiver_enable,
  // link bring-up status
  output logic      sync_request,
  output logic      cgs_active,
  output logic      ilas_start,
  output logic      link_data_phase,
  // oscillator synchronisation
  output logic      nco_sync_pulse,
  // sample marking
  output logic      marker_pulse,
  output logic      marker_tag
);

  lsts_main_state_t q;
  lsts_main_state_t d;

  // cleaned pins
  lsts_edge_if se_edge ();
  lsts_edge_if df_edge ();

  // selected sync level, high means no request
  logic sync_high;
  // pair level seen through its receiver enable
  logic diff_seen;
  // edges of the selected sync level
  logic sync_rose;
  logic sync_fell;
  // marker path is live
  logic marker_live;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  lsts_pin_sync #(
    .RESET_LEVEL (SYNC_IDLE_LEVEL)
  ) u_se_sync (
    .clk    (clk),
    .rst    (rst),
    .raw_in (single_ended_sync_in),
    .edge_o (se_edge)
  );

  lsts_pin_sync #(
    .RESET_LEVEL (MARKER_IDLE_LEVEL)
  ) u_df_sync (
    .clk    (clk),
    .rst    (rst),
    .raw_in (marker_diff_in),
    .edge_o (df_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // source selection
  always_comb begin
    // disabled receiver reads as released sync
    diff_seen = marker_receiver_enable ? df_edge.level : 1'b1;  // see [RL10]
    if (sync_source_select) begin
      // pair is active low like the pin; pin ignored here
      sync_high = diff_seen;  // see [RL6] see [RL9] see [RL11]
    end else begin
      sync_high = se_edge.level;  // see [RL1]
    end
  end

  // edges against the previous selected level
  assign sync_rose   = sync_high & ~q.prev_high;
  assign sync_fell   = ~sync_high & q.prev_high;
  // marking needs both its enable and the receiver
  assign marker_live = marker_enable & marker_receiver_enable;  // see [RL7] see [RL10]

  ////////////////////////////////////////////////////////////////////////////
  // bring-up state machine and pulse generation
  always_comb begin
    d              = q;
    d.prev_high    = sync_high;
    d.sync_request = ~sync_high;
    d.ilas_start   = 1'b0;
    d.nco_sync     = 1'b0;
    d.marker_pulse = 1'b0;
    d.marker_tag   = TAG_RESET;
    if (link_mode_64b66b) begin
      // 66b framing: sync drives oscillators only
      d.st       = LSTS_ST_IDLE;  // see [RL2]
      d.nco_sync = sync_fell;  // see [RL3]
    end else begin
      unique case (q.st)
        LSTS_ST_IDLE: begin
          if (!sync_high) begin
            d.st = LSTS_ST_CGS;  // see [RL4]
          end
        end
        LSTS_ST_CGS: begin
          if (sync_rose) begin
            d.st         = LSTS_ST_ILAS;  // see [RL5]
            d.ilas_start = 1'b1;  // see [RL5]
          end
        end
        LSTS_ST_ILAS: begin
          if (!sync_high) begin
            d.st = LSTS_ST_CGS;
          end else begin
            d.st = LSTS_ST_DATA;
          end
        end
        LSTS_ST_DATA: begin
          // receiver may re-request at any time
          if (!sync_high) begin
            d.st = LSTS_ST_CGS;  // see [RL4]
          end
        end
      endcase
    end
    // sample marking follows the pair level, sync included
    if (marker_live) begin
      d.marker_tag   = df_edge.level;  // see [RL7] see [RL8]
      d.marker_pulse = df_edge.rise;  // see [RL7]
    end
  end

  // register the whole state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{st: STATE_RESET, prev_high: SYNC_IDLE_LEVEL,
             sync_request: PULSE_RESET, ilas_start: PULSE_RESET,
             nco_sync: PULSE_RESET, marker_pulse: PULSE_RESET,
             marker_tag: TAG_RESET};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  assign sync_request    = q.sync_request;
  assign cgs_active      = (q.st == LSTS_ST_CGS);
  assign ilas_start      = q.ilas_start;
  assign link_data_phase = (q.st == LSTS_ST_DATA);
  assign nco_sync_pulse  = q.nco_sync;
  assign marker_pulse    = q.marker_pulse;
  assign marker_tag      = q.marker_tag;

  ////////////////////////////////////////////////////////////////////////////
  // single-ended low in 8b/10b with select 0 enters code group sync
  AST_SE_REQUEST: assert property (@(posedge clk) disable iff (rst)  // see [RL1]
    (!link_mode_64b66b && !sync_source_select && !se_edge.level)
      |=> (q.st == LSTS_ST_CGS) && q.sync_request)
    else $error("single-ended low did not start code group sync");

  // 66b mode holds the machine idle and never starts alignment
  AST_66B_NO_INIT: assert property (@(posedge clk) disable iff (rst)  // see [RL2]
    link_mode_64b66b |=> (q.st == LSTS_ST_IDLE) && !q.ilas_start)
    else $error("link bring-up moved in 64b/66b mode");

  // 66b mode turns a falling sync level into one oscillator pulse
  AST_66B_NCO_PULSE: assert property (@(posedge clk) disable iff (rst)  // see [RL3]
    (link_mode_64b66b && sync_fell) |=> q.nco_sync ##1 !q.nco_sync)
    else $error("missing or stretched oscillator sync pulse");

  // no oscillator pulse outside 66b mode
  AST_8B_NO_NCO: assert property (@(posedge clk) disable iff (rst)  // see [RL3]
    !link_mode_64b66b |=> !q.nco_sync)
    else $error("oscillator pulse in 8b/10b mode");

  // a held low request keeps the machine in code group sync
  AST_CGS_HOLD: assert property (@(posedge clk) disable iff (rst)  // see [RL4]
    (!link_mode_64b66b && !sync_high) [*2] |=> cgs_active)
    else $error("low sync did not hold code group sync");

  // alignment starts only from code group sync on a rising edge
  AST_ILAS_CAUSE: assert property (@(posedge clk) disable iff (rst)  // see [RL5]
    q.ilas_start |-> $past(q.st) == LSTS_ST_CGS && $past(sync_rose)
      && !$past(link_mode_64b66b))
    else $error("alignment start without rising edge from code group sync");

  // the rising edge out of code group sync starts alignment, then data, or code group sync again if the level drops
  AST_ILAS_SEQUENCE: assert property (@(posedge clk) disable iff (rst)  // see [RL5]
    (!link_mode_64b66b && q.st == LSTS_ST_CGS && sync_rose)
      |=> q.ilas_start ##1 (!q.ilas_start && (link_data_phase || cgs_active
      || q.st == LSTS_ST_IDLE)))
    else $error("alignment sequence did not follow the rising edge");

  // pair low with select 1 and receiver on enters code group sync
  AST_DIFF_REQUEST: assert property (@(posedge clk) disable iff (rst)  // see [RL6] see [RL9]
    (!link_mode_64b66b && sync_source_select && marker_receiver_enable
      && !df_edge.level) |=> cgs_active)
    else $error("differential low did not start code group sync");

  // pair high means released, even with the single-ended pin low
  AST_DIFF_IGNORES_SE: assert property (@(posedge clk) disable iff (rst)  // see [RL9] see [RL11]
    (!link_mode_64b66b && sync_source_select && marker_receiver_enable
      && df_edge.level && !se_edge.level && q.st == LSTS_ST_IDLE)
      |=> q.st == LSTS_ST_IDLE && !q.sync_request)
    else $error("single-ended pin leaked through with pair selected");

  // marker rising edge gives a one-cycle sample mark
  AST_MARKER_PULSE: assert property (@(posedge clk) disable iff (rst)  // see [RL7]
    (marker_live && df_edge.rise) |=> q.marker_pulse ##1 !q.marker_pulse)
    else $error("marker edge did not give a single pulse");

  // shared use: the tag mirrors the sync level on the pair
  AST_SHARED_TAG: assert property (@(posedge clk) disable iff (rst)  // see [RL8]
    (sync_source_select && marker_live)
      |=> q.marker_tag == $past(df_edge.level)
      && q.sync_request == !$past(df_edge.level))
    else $error("shared pair did not feed sync level into the tag");

  // receiver off: pair gives no marks and no request
  AST_RX_DISABLED: assert property (@(posedge clk) disable iff (rst)  // see [RL10]
    !marker_receiver_enable |=> !q.marker_pulse && !q.marker_tag
      && (!$past(sync_source_select) || !q.sync_request))
    else $error("pair acted with its receiver disabled");

  ////////////////////////////////////////////////////////////////////////////
  // alignment start lasts exactly one cycle
  AST_ILAS_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)  // see [RL5]
    q.ilas_start |=> !q.ilas_start)
    else $error("alignment start held longer than one cycle");

  // oscillator pulse only from a falling level in 66b mode
  AST_NCO_CAUSE: assert property (@(posedge clk) disable iff (rst)  // see [RL3]
    q.nco_sync |-> $past(link_mode_64b66b) && $past(sync_fell))
    else $error("oscillator pulse without a falling sync level");

  // sample mark only from a live pair edge
  AST_MARKER_CAUSE: assert property (@(posedge clk) disable iff (rst)  // see [RL7] see [RL10]
    q.marker_pulse |-> $past(marker_live) && $past(df_edge.rise))
    else $error("sample mark without a live pair edge");

  // live marking copies the cleaned pair level into the tag
  AST_TAG_FOLLOWS_PAIR: assert property (@(posedge clk) disable iff (rst)  // see [RL7]
    marker_live |=> q.marker_tag == $past(df_edge.level))
    else $error("tag does not follow the pair level");

  // marking off gives neither tag nor mark
  AST_TAG_IDLE: assert property (@(posedge clk) disable iff (rst)  // see [RL7]
    !marker_enable |=> !q.marker_tag && !q.marker_pulse)
    else $error("tag or mark with marking disabled");

  // select 0: request is the inverted single-ended level
  AST_SE_TO_REQ: assert property (@(posedge clk) disable iff (rst)  // see [RL1]
    !sync_source_select |=> q.sync_request == !$past(se_edge.level))
    else $error("request does not follow the single-ended pin");

  // select 1 with receiver on: request is the inverted pair level
  AST_PAIR_TO_REQ: assert property (@(posedge clk) disable iff (rst)  // see [RL6] see [RL9]
    (sync_source_select && marker_receiver_enable)
      |=> q.sync_request == !$past(df_edge.level))
    else $error("request does not follow the pair");

  // pair selected with its receiver off reads as released
  AST_RX_OFF_RELEASED: assert property (@(posedge clk) disable iff (rst)  // see [RL10]
    (sync_source_select && !marker_receiver_enable) |=> !q.sync_request && !q.nco_sync)
    else $error("disabled pair gave a sync request");

  // select 1: the single-ended pin plays no part in the request
  AST_SE_IGNORED: assert property (@(posedge clk) disable iff (rst)  // see [RL11]
    sync_source_select |=> q.sync_request == !$past(diff_seen))
    else $error("single-ended pin reached the request with pair selected");

  // 66b mode shows neither code group sync nor data phase
  AST_66B_NO_PHASE: assert property (@(posedge clk) disable iff (rst)  // see [RL2]
    link_mode_64b66b |=> !cgs_active && !link_data_phase)
    else $error("bring-up phase shown in 64b/66b mode");

  // data phase is entered only through alignment
  AST_DATA_ENTRY: assert property (@(posedge clk) disable iff (rst)  // see [RL5]
    $rose(link_data_phase) |-> $past(q.st) == LSTS_ST_ILAS)
    else $error("data phase entered without alignment");

  // in 8b/10b modes code group sync is left only on a rising edge
  AST_CGS_STAYS: assert property (@(posedge clk) disable iff (rst)  // see [RL5]
    (!link_mode_64b66b && cgs_active && !sync_rose) |=> cgs_active)
    else $error("code group sync left without a rising edge");

  // a released line leaves the idle machine alone
  AST_IDLE_HIGH_STAYS: assert property (@(posedge clk) disable iff (rst)  // see [RL4]
    (!link_mode_64b66b && q.st == LSTS_ST_IDLE && sync_high) |=> q.st == LSTS_ST_IDLE)
    else $error("idle machine moved without a request");

  // a new low request in data phase goes back to code group sync
  AST_DATA_REREQUEST: assert property (@(posedge clk) disable iff (rst)  // see [RL4]
    (!link_mode_64b66b && link_data_phase && !sync_high) |=> cgs_active)
    else $error("request in data phase did not restart code group sync");

endmodule : lsts_top

// >>> inc/lsts_edge_if.sv
`timescale 1ns/1ps
// cleaned level and edges of one synchronised pin
interface lsts_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : lsts_edge_if

// >>> inc/lsts_pkg.sv
package lsts_pkg;

  // idle level of the active-low sync pins after reset
  localparam logic SYNC_IDLE_LEVEL   = 1'b1;
  // idle level of the marker pair after reset
  localparam logic MARKER_IDLE_LEVEL = 1'b0;
  // reset values of the request, pulse and tag outputs
  localparam logic PULSE_RESET       = 1'b0;
  localparam logic TAG_RESET         = 1'b0;

  // link bring-up states
  typedef enum logic [1:0] {
    LSTS_ST_IDLE = 2'b00,
    LSTS_ST_CGS  = 2'b01,
    LSTS_ST_ILAS = 2'b10,
    LSTS_ST_DATA = 2'b11
  } lsts_state_t;

  localparam lsts_state_t STATE_RESET = LSTS_ST_IDLE;

  // state of one pin synchroniser
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } lsts_sync_state_t;

  // state of the selection and bring-up logic
  typedef struct packed {
    lsts_state_t st;
    logic        prev_high;
    logic        sync_request;
    logic        ilas_start;
    logic        nco_sync;
    logic        marker_pulse;
    logic        marker_tag;
  } lsts_main_state_t;

endpackage : lsts_pkg

// >>> verif/lsts_rx_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// far-side receiver: pulls sync low on request, then releases
module lsts_rx_model (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // request and length of the low phase
  input wire logic       req,
  input wire logic [3:0] hold,
  // active-low sync line
  output logic           sync_n
);
  logic [3:0] cnt_q;
  // low while counting down, high otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_n <= 1'b1;
      cnt_q  <= 4'h0;
    end else if (req && sync_n) begin
      sync_n <= 1'b0;
      cnt_q  <= hold;
    end else if (!sync_n) begin
      if (cnt_q == 4'h0) sync_n <= 1'b1;
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : lsts_rx_model

// >>> verif/test_link_sync_timestamp_input_select.sv
`timescale 1ns/1ps
module test_link_sync_timestamp_input_select
  import lsts_pkg::*;
;
  // stimulus
  logic       clk, rst, se, pair, mode, sel, men, rxen, req, rx_n;
  logic       noise = 1'b0;
  logic [3:0] hold;
  logic [1:0] nc = 2'h0;
  logic [31:0] r, rn;
  // design outputs
  logic       o_req, o_cgs, o_ilas, o_data, o_nco, o_mp, o_mt;
  // reference model
  int         s1[2], s2[2], s3[2], lv[2], rs[2], p[2];
  int         st, ph, sv, live, nl, e_req, e_ilas, e_nco, e_mp, e_mt;
  int         seed = 28830;
  int         bad_count = 0;
  int         tests_run = 0;

  ////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // selected pin follows the receiver, the other carries noise
  assign se   = sel ? noise : rx_n;
  assign pair = sel ? rx_n : noise;

  lsts_top lsts_top_i (
    .clk(clk), .rst(rst), .single_ended_sync_in(se), .marker_diff_in(pair),
    .link_mode_64b66b(mode), .sync_source_select(sel), .marker_enable(men),
    .marker_receiver_enable(rxen), .sync_request(o_req), .cgs_active(o_cgs),
    .ilas_start(o_ilas), .link_data_phase(o_data), .nco_sync_pulse(o_nco),
    .marker_pulse(o_mp), .marker_tag(o_mt)
  );

  lsts_rx_model lsts_rx_model_i (
    .clk(clk), .rst(rst), .req(req), .hold(hold), .sync_n(rx_n)
  );

  ////////////////////////////////////////////////////////////////
  // noise that holds four cycles
  always @(posedge clk) begin
    nc <= nc + 2'h1;
    if (nc == 2'h0) begin
      rn = $random(seed);
      noise <= rn[0];
    end
  end

  // reference model of pin path and bring-up
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 = '{1, 0};
      s2 = '{1, 0};
      s3 = '{1, 0};
      lv = '{1, 0};
      rs = '{0, 0};
      {st, e_req, e_ilas, e_nco, e_mp, e_mt} = '0;
      ph = 1;
    end else begin
      sv = sel ? (rxen ? lv[1] : 1) : lv[0];
      live = men && rxen;
      e_req = !sv;
      e_ilas = !mode && st == 1 && sv && !ph;
      e_nco = mode && ph && !sv;
      e_mp = live && rs[1];
      e_mt = live && lv[1];
      if (mode) st = 0;
      else if (st == 0) st = sv ? 0 : 1;
      else if (st == 1) st = (sv && !ph) ? 2 : 1;
      else st = sv ? 3 : 1;
      ph = sv;
      p = '{se, pair};
      for (int k = 0; k < 2; k++) begin
        nl = (s2[k] == s3[k]) ? s3[k] : lv[k];
        rs[k] = nl && !lv[k];
        lv[k] = nl;
        s3[k] = s2[k];
        s2[k] = s1[k];
        s1[k] = p[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // compare tasks
  task automatic chk_lvl(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t level got %b exp %b", $time, got, exp);
    end
  endtask : chk_lvl

  task automatic chk_pls(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t pulse got %b exp %b", $time, got, exp);
    end
  endtask : chk_pls

  task automatic stop_test();
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  // compare every output each cycle
  always @(negedge clk) begin
    if (!rst) begin
      chk_lvl(o_req, e_req[0]);
      chk_lvl(o_cgs, st == 1);
      chk_pls(o_ilas, e_ilas[0]);
      chk_lvl(o_data, st == 3);
      chk_pls(o_nco, e_nco[0]);
      chk_pls(o_mp, e_mp[0]);
      chk_lvl(o_mt, e_mt[0]);
    end
  end

  ////////////////////////////////////////////////////////////////
  // every config combination, two requests each, random hold;
  // mode alternates so each 8b/10b config starts from an idle machine
  initial begin
    {mode, sel, men, rxen, req} = 5'h00;
    hold = 4'h3;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      {sel, men, rxen, mode} <= i[3:0];
      repeat (2) begin
        @(posedge clk);
        r = $random(seed);
        req  <= 1'b1;
        hold <= 4'h3 + {1'b0, r[2:0]};
        @(posedge clk);
        req <= 1'b0;
        repeat (40) @(posedge clk);
      end
    end
    // reset in mid-run, then one more request on the single-ended pin
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    {sel, men, rxen, mode} <= 4'h0;
    @(posedge clk);
    req  <= 1'b1;
    hold <= 4'h5;
    @(posedge clk);
    req <= 1'b0;
    repeat (40) @(posedge clk);
    stop_test();
  end

  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    stop_test();
  end
endmodule : test_link_sync_timestamp_input_select
